// [itm_pkg.sv]
// shared constants and types for the timecode master control block
`default_nettype none
package itm_pkg;

    // ---------------------------------------------------------------
    // register map (byte offsets)
    // ---------------------------------------------------------------
    localparam logic [4:0] OFF_CTRL   = 5'h00;
    localparam logic [4:0] OFF_CFG    = 5'h04;
    localparam logic [4:0] OFF_CBITS  = 5'h08;
    localparam logic [4:0] OFF_LEAP   = 5'h0c;
    localparam logic [4:0] OFF_PROP   = 5'h10;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT  = 0;
    localparam int CTRL_DISABLE_BIT = 1;
    localparam int CTRL_RESET_BIT   = 2;
    localparam int CFG_TYPE_LSB     = 0;
    localparam int CFG_PIN_LSB      = 4;
    localparam int LEAP_DAY_LSB     = 8;
    localparam int LEAP_HOUR_LSB    = 18;
    localparam int CBITS_W          = 18;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [CBITS_W-1:0] CBITS_RST = 18'h00000;
    localparam logic [7:0]         PROP_RST  = 8'h00;
    localparam logic [1:0]         TYPE_RST  = 2'h0;
    localparam logic [3:0]         PIN_RST   = 4'h0;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_NS       = 100;
    localparam int PROP_STEP_NS = 400;
    localparam int PROP_MAX_NS  = 65520;
    localparam int PROP_STEP_CYC = PROP_STEP_NS / CLK_NS;
    localparam logic [7:0] PROP_MAX_STEPS = 8'(PROP_MAX_NS / PROP_STEP_NS);
    localparam int SEC_NS       = 1000000000;
    localparam int BIT_NS       = 10000000;
    localparam int MARK_NS      = 8000000;
    localparam int ONE_NS       = 5000000;
    localparam int ZERO_NS      = 2000000;
    localparam int FRAME_BITS   = 100;
    localparam logic [6:0] LEAP_MIN = 7'h59;
    localparam logic [6:0] LEAP_SEC = 7'h59;
    localparam logic [6:0] SEC_60   = 7'h60;

    // ---------------------------------------------------------------
    // carriers (all fields bcd)
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [7:0] year;
        logic [9:0] day;
        logic [5:0] hour;
        logic [6:0] min;
        logic [6:0] sec;
    } itm_tod_t;

    typedef struct packed {
        logic [5:0] hour;
        logic [9:0] day;
        logic [7:0] year;
    } itm_leap_t;

endpackage
`default_nettype wire

// [itm_master.sv]
// timecode master control: register slave, leap and offset logic, dcls encoder
// ---------------------------------------------------------------
// What this block does
// - while enabled, frames of the time input are sent every second unattended.
// - while disabled, no timecode leaves the output.
// - status read returns 1 while enabled, 0 otherwise.
// - master reset clears every setting, including output type and pin.
// - control bits go into each frame; reads show 18 meaningful bits.
// - control bits write keeps the low 18 bits, drops the rest.
// - leap year, day and hour are held and read back.
// - leap second inserted after second 59 of minute 59 of that hour.
// - output advanced by 0 to 65200 ns in 400 ns steps, default 0.
// ---------------------------------------------------------------
//
// Our own choices: the address map and the Avalon-MM register port.
`default_nettype none
module itm_master
    import itm_pkg::*;
#(
    parameter int SEC_CYC  = SEC_NS / CLK_NS,
    parameter int BIT_CYC  = BIT_NS / CLK_NS,
    parameter int MARK_CYC = MARK_NS / CLK_NS,
    parameter int ONE_CYC  = ONE_NS / CLK_NS,
    parameter int ZERO_CYC = ZERO_NS / CLK_NS
)
(
    input  wire logic           REF_CLK_IN,
    input  wire logic           RSTN_IN,
    input  wire logic [4:0]     AVS_ADDRESS_IN,
    input  wire logic           AVS_READ_IN,
    input  wire logic           AVS_WRITE_IN,
    input  wire logic [31:0]    AVS_WRITEDATA_IN,
    input  wire logic [3:0]     AVS_BYTEENABLE_IN,
    output logic [31:0]         AVS_READDATA_OUT,
    output logic                AVS_WAITREQUEST_OUT,
    input  wire itm_pkg::itm_tod_t TOD_IN,
    input  wire logic           PPS_IN,
    output logic                IRIG_DCLS_OUT,
    output logic [1:0]          OUT_TYPE_OUT,
    output logic [3:0]          OUT_PIN_OUT,
    output logic                ACTIVE_OUT
);
    import itm_pkg::*;

    // ---------------------------------------------------------------
    // bus slave: one wait cycle, answer on the second
    // ---------------------------------------------------------------
    logic                ack_r;
    logic [31:0]         rdata_r;
    logic                en_r;
    logic [1:0]          type_r;
    logic [3:0]          pin_r;
    logic [CBITS_W-1:0]  cbits_r;
    itm_leap_t           leap_r;
    logic [7:0]          prop_r;

    wire        req      = AVS_READ_IN | AVS_WRITE_IN;
    wire        do_wr    = AVS_WRITE_IN & ack_r;
    wire        do_rd    = AVS_READ_IN & ack_r;
    wire [31:0] bmask    = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}},
                            {8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};
    wire [31:0] wd       = AVS_WRITEDATA_IN & bmask;
    wire        sel_ctrl = AVS_ADDRESS_IN == OFF_CTRL;
    wire        sel_cfg  = AVS_ADDRESS_IN == OFF_CFG;
    wire        sel_cbit = AVS_ADDRESS_IN == OFF_CBITS;
    wire        sel_leap = AVS_ADDRESS_IN == OFF_LEAP;
    wire        sel_prop = AVS_ADDRESS_IN == OFF_PROP;
    wire        wr_ctrl  = do_wr & sel_ctrl;
    wire        m_reset  = wr_ctrl & wd[CTRL_RESET_BIT];
    wire        m_en     = wr_ctrl & wd[CTRL_ENABLE_BIT];
    wire        m_dis    = wr_ctrl & wd[CTRL_DISABLE_BIT];

    // mask and data come in as arguments: a continuous assignment only wakes on what it passes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] msk, input logic [31:0] nw);
        merge = (old & ~msk) | nw;
    endfunction

    wire [31:0] cfg_word  = {24'h000000, pin_r, 2'h0, type_r};
    wire [31:0] leap_word = {8'h00, leap_r};
    wire [31:0] cb_merge  = merge({14'h0000, cbits_r}, bmask, wd);
    wire [31:0] cf_merge  = merge(cfg_word, bmask, wd);
    wire [31:0] lp_merge  = merge(leap_word, bmask, wd);
    wire [31:0] pr_merge  = merge({24'h000000, prop_r}, bmask, wd);
    wire [7:0]  prop_nxt  = (pr_merge[7:0] > PROP_MAX_STEPS) ? PROP_MAX_STEPS : pr_merge[7:0];

    // unmapped addresses read as zero and ignore writes
    wire [31:0] rd_mux =
        sel_ctrl ? {31'h00000000, en_r} :
        sel_cfg  ? cfg_word :
        sel_cbit ? {14'h0000, cbits_r} :
        sel_leap ? leap_word :
        sel_prop ? {24'h000000, prop_r} : 32'h00000000;

    assign AVS_WAITREQUEST_OUT = req & ~ack_r;
    assign AVS_READDATA_OUT    = rdata_r;

    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h00000000;
        end
        else
        begin
            ack_r   <= req & ~ack_r;
            rdata_r <= rd_mux;
        end
    end

    // ---------------------------------------------------------------
    // settings; master reset wins over a same-word enable
    // ---------------------------------------------------------------
    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RSTN_IN || m_reset)
        begin
            en_r    <= 1'b0;
            type_r  <= TYPE_RST;
            pin_r   <= PIN_RST;
            cbits_r <= CBITS_RST;
            leap_r  <= '0;
            prop_r  <= PROP_RST;
        end
        else
        begin
            if (m_en)
                en_r <= 1'b1;
            else if (m_dis)
                en_r <= 1'b0;
            if (do_wr && sel_cfg)
            begin
                type_r <= cf_merge[CFG_TYPE_LSB +: 2];
                pin_r  <= cf_merge[CFG_PIN_LSB +: 4];
            end
            if (do_wr && sel_cbit)
                cbits_r <= cb_merge[CBITS_W-1:0];
            if (do_wr && sel_leap)
                leap_r <= lp_merge[23:0];
            if (do_wr && sel_prop)
                prop_r <= prop_nxt;
        end
    end

    assign OUT_TYPE_OUT = type_r;
    assign OUT_PIN_OUT  = pin_r;
    assign ACTIVE_OUT   = en_r;

    // ---------------------------------------------------------------
    // second timing: pps aligns, free runs without it
    // ---------------------------------------------------------------
    logic [23:0] cyc_r;
    wire  [23:0] off_cyc = 24'(prop_r * PROP_STEP_CYC);
    wire  [23:0] trig_pt = 24'(SEC_CYC - 1) - off_cyc;
    wire         start   = (cyc_r == trig_pt) & en_r;

    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RSTN_IN || PPS_IN || cyc_r == 24'(SEC_CYC - 1))
            cyc_r <= 24'h000000;
        else
            cyc_r <= cyc_r + 24'h000001;
    end

    // ---------------------------------------------------------------
    // frame assembly; tod is the time of the coming on-time mark
    // ---------------------------------------------------------------
    function automatic logic [FRAME_BITS-1:0] build(input itm_tod_t t, input logic [CBITS_W-1:0] cb);
        logic [FRAME_BITS-1:0] f;
        f = '0;
        f[4:1]   = t.sec[3:0];
        f[8:6]   = t.sec[6:4];
        f[13:10] = t.min[3:0];
        f[17:15] = t.min[6:4];
        f[23:20] = t.hour[3:0];
        f[26:25] = t.hour[5:4];
        f[33:30] = t.day[3:0];
        f[38:35] = t.day[7:4];
        f[41:40] = t.day[9:8];
        f[53:50] = t.year[3:0];
        f[58:55] = t.year[7:4];
        f[68:60] = cb[8:0];
        f[78:70] = cb[17:9];
        build = f;
    endfunction

    logic                  leap_next_r;
    itm_tod_t              last_r;
    logic [FRAME_BITS-1:0] frame_r;
    logic                  busy_r;
    logic [6:0]            idx_r;
    logic [16:0]           bcyc_r;

    // a leap frame repeats the held minute with second 60; system time must hold the step
    itm_tod_t leap_tod;
    assign leap_tod = '{year: last_r.year, day: last_r.day, hour: last_r.hour,
                        min: last_r.min, sec: SEC_60};
    wire leap_hit = TOD_IN.year == leap_r.year && TOD_IN.day == leap_r.day
                    && TOD_IN.hour == leap_r.hour && TOD_IN.min == LEAP_MIN
                    && TOD_IN.sec == LEAP_SEC;
    wire [FRAME_BITS-1:0] frame_nxt = leap_next_r ? build(leap_tod, cbits_r) : build(TOD_IN, cbits_r);

    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RSTN_IN || m_reset)
        begin
            leap_next_r <= 1'b0;
            last_r      <= '0;
            frame_r     <= '0;
        end
        else if (start)
        begin
            leap_next_r <= ~leap_next_r & leap_hit;
            last_r      <= TOD_IN;
            frame_r     <= frame_nxt;
        end
    end

    // ---------------------------------------------------------------
    // pulse-width encoder: marker, one or zero per 10 ms slot
    // ---------------------------------------------------------------
    wire        last_cyc = bcyc_r == 17'(BIT_CYC - 1);
    wire        is_mark  = idx_r == 7'h00 || (idx_r % 7'h0a) == 7'h09;
    wire [16:0] width    = is_mark ? 17'(MARK_CYC) : frame_r[idx_r] ? 17'(ONE_CYC) : 17'(ZERO_CYC);
    wire        lvl_nxt  = busy_r & en_r & (bcyc_r < width);

    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RSTN_IN || !en_r)
        begin
            busy_r <= 1'b0;
            idx_r  <= 7'h00;
            bcyc_r <= 17'h00000;
        end
        else if (start)
        begin
            busy_r <= 1'b1;
            idx_r  <= 7'h00;
            bcyc_r <= 17'h00000;
        end
        else if (busy_r)
        begin
            bcyc_r <= last_cyc ? 17'h00000 : bcyc_r + 17'h00001;
            if (last_cyc)
            begin
                idx_r  <= (idx_r == 7'(FRAME_BITS - 1)) ? 7'h00 : idx_r + 7'h01;
                busy_r <= idx_r != 7'(FRAME_BITS - 1);
            end
        end
    end

    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RSTN_IN)
            IRIG_DCLS_OUT <= 1'b0;
        else
            IRIG_DCLS_OUT <= lvl_nxt & ~(m_dis & ~m_en) & ~m_reset;
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb_main @(posedge REF_CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    sequence s_enable_req;
        wr_ctrl && wd[CTRL_ENABLE_BIT] && !wd[CTRL_RESET_BIT];
    endsequence

    sequence s_frame_begins;
        busy_r && idx_r == 7'h00 && bcyc_r == 17'h00000;
    endsequence

    a_quiet_when_off: assert property (!en_r |=> !IRIG_DCLS_OUT)
        else $error("timecode driven while disabled");
    a_status_read: assert property (do_rd && sel_ctrl |-> AVS_READDATA_OUT == {31'h00000000, en_r})
        else $error("status read mismatch");
    a_enable_flag: assert property (s_enable_req |=> en_r && ACTIVE_OUT)
        else $error("enable not taken on accepting edge");
    a_reset_clears: assert property (m_reset |=> !en_r && type_r == TYPE_RST && pin_r == PIN_RST
                                     && cbits_r == CBITS_RST && prop_r == PROP_RST)
        else $error("master reset left settings");
    a_cbits_store: assert property (do_wr && sel_cbit && AVS_BYTEENABLE_IN == 4'hf && !m_reset
                                    |=> cbits_r == $past(AVS_WRITEDATA_IN[CBITS_W-1:0]))
        else $error("control bits not stored");
    a_cbits_upper: assert property (do_rd && sel_cbit |-> AVS_READDATA_OUT[31:CBITS_W] == 14'h0000)
        else $error("control bits upper bits set");
    a_leap_read: assert property (do_rd && sel_leap |-> AVS_READDATA_OUT[23:0] == leap_r)
        else $error("leap readback mismatch");
    a_frame_start: assert property (start && !m_dis && !m_reset |=> s_frame_begins)
        else $error("frame did not begin");
    a_leap_second: assert property (start && leap_next_r && !m_reset
                                    |=> frame_r[8:1] == {SEC_60[6:4], 1'b0, SEC_60[3:0]})
        else $error("leap frame lacks second 60");
    a_offset_range: assert property (prop_r <= PROP_MAX_STEPS)
        else $error("offset beyond range");
    a_marker_width: assert property (busy_r && is_mark && bcyc_r == 17'h00000 && en_r && !m_dis && !m_reset
                                     ##1 !m_dis && !m_reset |-> IRIG_DCLS_OUT [*2])
        else $error("marker too short");

endmodule
`default_nettype wire

// [itm_rx_model.sv]
// behavioural timecode receiver that decodes the dcls line into frames
`default_nettype none
module itm_rx_model
#(
    parameter int MARK_CYC = 16,
    parameter int ONE_CYC  = 10,
    parameter int ZERO_CYC = 4
)
(
    input  wire logic   clk_in,
    input  wire logic   dcls_in,
    output logic [99:0] frame_out,
    output logic [15:0] frames_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [99:0] bits_r = '0;
    logic [7:0]  idx_r  = 8'hff;
    int          hi_r   = 0;
    int          lo_r   = 0;
    logic        mark_r = 1'b0;
    logic        is_mark;
    logic        is_one;

    initial frame_out = '0;
    initial frames_out = '0;
    assign is_mark = hi_r > (MARK_CYC + ONE_CYC) / 2;
    assign is_one  = hi_r > (ONE_CYC + ZERO_CYC) / 2;

    // a long idle drops sync, so a cut frame is never reported as whole
    always @(posedge clk_in)
    begin
        hi_r <= dcls_in ? hi_r + 1 : 0;
        lo_r <= dcls_in ? 0 : lo_r + 1;
        if (lo_r > 4 * MARK_CYC)
            idx_r <= 8'hff;
        if (!dcls_in && hi_r != 0)
        begin
            mark_r <= is_mark;
            if (is_mark && mark_r)
                idx_r <= 8'h01;
            else if (idx_r < 8'h64)
            begin
                bits_r[idx_r] <= is_one && !is_mark;
                idx_r <= idx_r + 8'h01;
                if (idx_r == 8'h63)
                begin
                    frame_out  <= bits_r;
                    frames_out <= frames_out + 16'h0001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [test_itm_master.sv]
// self-checking bench for the timecode master control block
`default_nettype none
module test_itm_master;
    timeunit 1ns;
    timeprecision 1ns;
    import itm_pkg::*;

    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    localparam int SEC = 2000;
    localparam int BIT = 20;
    localparam int MARK = 16;
    localparam int ONE = 10;
    localparam int ZERO = 4;
    logic [3:0]  be    = 4'hf;
    logic        clk   = 1'b0;
    logic        rstn  = 1'b0;
    logic [4:0]  addr  = 5'h00;
    logic        rd    = 1'b0;
    logic        wr    = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic        waitreq;
    itm_tod_t    tod   = '0;
    logic        pps   = 1'b0;
    logic        dcls;
    logic        active;
    logic [1:0]  otype;
    logic [3:0]  opin;
    logic [99:0] frame;
    logic [15:0] frames;
    logic        wq_s;
    logic        act_s;
    logic [31:0] rd_s;
    logic [31:0] rv;
    int          fail_count = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          n0;
    int          n1;
    int          hi;
    itm_tod_t    leap_t = '{8'h24, 10'h100, 6'h12, 7'h59, 7'h59};
    logic [4:0]  offs [6] = '{OFF_CTRL, OFF_CFG, OFF_CBITS, OFF_LEAP, OFF_PROP, 5'h14};

    always #50 clk = ~clk;

    itm_master #(.SEC_CYC(SEC), .BIT_CYC(BIT), .MARK_CYC(MARK), .ONE_CYC(ONE), .ZERO_CYC(ZERO)) i_dut (
        .REF_CLK_IN(clk), .RSTN_IN(rstn), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
        .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata),
        .AVS_WAITREQUEST_OUT(waitreq), .TOD_IN(tod), .PPS_IN(pps), .IRIG_DCLS_OUT(dcls),
        .OUT_TYPE_OUT(otype), .OUT_PIN_OUT(opin), .ACTIVE_OUT(active));

    itm_rx_model #(.MARK_CYC(MARK), .ONE_CYC(ONE), .ZERO_CYC(ZERO)) i_rx (
        .clk_in(clk), .dcls_in(dcls), .frame_out(frame), .frames_out(frames));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // mid-cycle copies keep sampling clear of the edge that updates them
    always @(negedge clk)
    begin
        wq_s  <= waitreq;
        rd_s  <= rdata;
        act_s <= active;
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            fail_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [99:0] got, input logic [99:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        rd    <= ~w;
        wr    <= w;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        while (wq_s !== 1'b0) @(posedge clk);
        rv = rd_s;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic zeros();
        foreach (offs[i])
        begin
            bus(1'b0, offs[i], 32'h0);
            check(rv, 32'h0);
        end
    endtask

    task automatic next_frame(input int n);
        logic [15:0] f0;
        f0 = frames;
        while (frames - f0 < n) @(posedge clk);
    endtask

    // the mark is counted from the pps pulse, so only differences are meaningful
    task automatic measure(input logic [7:0] p, output int n);
        time t0;
        bus(1'b1, OFF_CTRL, 32'h2);
        bus(1'b1, OFF_PROP, {24'h0, p});
        pps <= 1'b1;
        @(posedge clk);
        pps <= 1'b0;
        t0 = $time;
        bus(1'b1, OFF_CTRL, 32'h1);
        while (dcls !== 1'b1) @(posedge clk);
        n = int'(($time - t0) / 100);
    endtask

    function automatic logic [99:0] exp_frame(input itm_tod_t t, input logic [17:0] cb);
        logic [99:0] f;
        f        = '0;
        f[4:1]   = t.sec[3:0];
        f[8:6]   = t.sec[6:4];
        f[13:10] = t.min[3:0];
        f[17:15] = t.min[6:4];
        f[23:20] = t.hour[3:0];
        f[26:25] = t.hour[5:4];
        f[33:30] = t.day[3:0];
        f[38:35] = t.day[7:4];
        f[41:40] = t.day[9:8];
        f[53:50] = t.year[3:0];
        f[58:55] = t.year[7:4];
        f[68:60] = cb[8:0];
        f[78:70] = cb[17:9];
        return f;
    endfunction

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        zeros();
        bus(1'b1, OFF_CBITS, 32'hfffa5aff);
        be <= 4'h1;
        bus(1'b1, OFF_CBITS, 32'hffffff5a);
        be <= 4'hf;
        bus(1'b0, OFF_CBITS, 32'h0);
        check(rv, 32'h25a5a);
        bus(1'b1, OFF_LEAP, {8'h00, 6'h12, 10'h100, 8'h24});
        bus(1'b0, OFF_LEAP, 32'h0);
        check(rv, {8'h00, 6'h12, 10'h100, 8'h24});
        bus(1'b1, OFF_CFG, 32'h52);
        bus(1'b1, 5'h14, 32'hffffffff);
        bus(1'b0, 5'h14, 32'h0);
        check({rv, otype, opin}, 38'h25);
        tod <= '{8'h24, 10'h100, 6'h12, 7'h34, 7'h56};
        bus(1'b1, OFF_CTRL, 32'h1);
        check(act_s, 1'b1);
        bus(1'b0, OFF_CTRL, 32'h0);
        check(rv, 32'h1);
        next_frame(2);
        check(frame, exp_frame(tod, 18'h25a5a));
        repeat (1000) @(posedge clk);
        tod <= leap_t;
        next_frame(2);
        check(frame, exp_frame(leap_t, 18'h25a5a));
        next_frame(1);
        check(frame, exp_frame({leap_t[37:7], 7'h60}, 18'h25a5a));
        repeat (500) @(posedge clk);
        bus(1'b1, OFF_CTRL, 32'h2);
        check(act_s, 1'b0);
        bus(1'b0, OFF_CTRL, 32'h0);
        check(rv, 32'h0);
        hi = 0;
        repeat (2500)
        begin
            @(posedge clk);
            if (dcls !== 1'b0)
                hi++;
        end
        check(hi, 0);
        bus(1'b1, OFF_CFG, 32'h52);
        bus(1'b1, OFF_CTRL, 32'h3);
        check(act_s, 1'b1);
        bus(1'b1, OFF_CTRL, 32'h7);
        check({act_s, otype, opin}, 7'h00);
        zeros();
        measure(8'h00, n0);
        measure(8'hff, n1);
        bus(1'b0, OFF_PROP, 32'h0);
        check(rv, 32'ha3);
        check(n0 - n1, 652);
        close_out();
    end
endmodule
`default_nettype wire
